// [src/backplane_channel_timing.sv]
// Top: APB registers and the receive and transmit backplane paths
module backplane_channel_timing (
   // System clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Receive backplane
   input wire logic rx_bp_clk,
   input wire logic rx_frame_sync_pin,
   output logic rx_channel_block_out,
   output logic rx_channel_clock_out,
   // Transmit backplane
   input wire logic tx_bp_clk,
   input wire logic tx_sys_frame_sync_pin,
   output logic tx_channel_block_out,
   output logic tx_channel_clock_out
);
   import bpt_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] rx_io_control_reg, tx_io_control_reg;
   logic [7:0] rx_elastic_store_ctrl, tx_elastic_store_ctrl;
   logic [7:0] rx_channel_block_regs [NUM_BLK_REGS];
   logic [7:0] tx_channel_block_regs [NUM_BLK_REGS];
   logic [7:0] rx_gapclk_select_regs [NUM_BLK_REGS];
   logic [7:0] tx_gapclk_select_regs [NUM_BLK_REGS];
   logic [31:0] rx_blk_flat, tx_blk_flat, rx_gcs_flat, tx_gcs_flat;
   logic access, wr, mapped;
   logic [1:0] idx;
   logic rx_bp_rst, tx_bp_rst;
   logic [4:0] rx_chan, tx_chan;
   logic [4:0] rx_chan_sys, tx_chan_sys;
   // No wait states; unmapped offsets answer with an error
   assign access = psel & penable;
   assign pready = 1'b1;
   assign wr = access & pwrite;
   assign idx = paddr[3:2];
   assign mapped = (paddr[1:0] == 2'h0) && (paddr == OFS_RX_IO_CTRL
      || paddr == OFS_TX_IO_CTRL || paddr == OFS_RX_ES_CTRL
      || paddr == OFS_TX_ES_CTRL || paddr == OFS_STATUS
      || (paddr & GROUP_MASK) == OFS_RX_BLK || (paddr & GROUP_MASK) == OFS_TX_BLK
      || (paddr & GROUP_MASK) == OFS_RX_GCS || (paddr & GROUP_MASK) == OFS_TX_GCS);
   assign pslverr = access & ~mapped;
   // Control register writes
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rx_io_control_reg <= REG_RESET;
         tx_io_control_reg <= REG_RESET;
         rx_elastic_store_ctrl <= REG_RESET;
         tx_elastic_store_ctrl <= REG_RESET;
      end else if (wr) begin
         if (paddr == OFS_RX_IO_CTRL) rx_io_control_reg <= pwdata[7:0];
         if (paddr == OFS_TX_IO_CTRL) tx_io_control_reg <= pwdata[7:0];
         if (paddr == OFS_RX_ES_CTRL) rx_elastic_store_ctrl <= pwdata[7:0];
         if (paddr == OFS_TX_ES_CTRL) tx_elastic_store_ctrl <= pwdata[7:0];
      end
   end
   // Channel map register writes
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         for (int i = 0; i < NUM_BLK_REGS; i++) begin
            rx_channel_block_regs[i] <= REG_RESET;
            tx_channel_block_regs[i] <= REG_RESET;
            rx_gapclk_select_regs[i] <= REG_RESET;
            tx_gapclk_select_regs[i] <= REG_RESET;
         end
      end else if (wr) begin
         if ((paddr & GROUP_MASK) == OFS_RX_BLK) rx_channel_block_regs[idx] <= pwdata[7:0];
         if ((paddr & GROUP_MASK) == OFS_TX_BLK) tx_channel_block_regs[idx] <= pwdata[7:0];
         if ((paddr & GROUP_MASK) == OFS_RX_GCS) rx_gapclk_select_regs[idx] <= pwdata[7:0];
         if ((paddr & GROUP_MASK) == OFS_TX_GCS) tx_gapclk_select_regs[idx] <= pwdata[7:0];
      end
   end
   // Read mux; status shows the live channel numbers
   always_comb begin
      prdata = READ_ZERO;
      if (access && !pwrite) begin
         if (paddr == OFS_RX_IO_CTRL) prdata[7:0] = rx_io_control_reg;
         if (paddr == OFS_TX_IO_CTRL) prdata[7:0] = tx_io_control_reg;
         if (paddr == OFS_RX_ES_CTRL) prdata[7:0] = rx_elastic_store_ctrl;
         if (paddr == OFS_TX_ES_CTRL) prdata[7:0] = tx_elastic_store_ctrl;
         if ((paddr & GROUP_MASK) == OFS_RX_BLK) prdata[7:0] = rx_channel_block_regs[idx];
         if ((paddr & GROUP_MASK) == OFS_TX_BLK) prdata[7:0] = tx_channel_block_regs[idx];
         if ((paddr & GROUP_MASK) == OFS_RX_GCS) prdata[7:0] = rx_gapclk_select_regs[idx];
         if ((paddr & GROUP_MASK) == OFS_TX_GCS) prdata[7:0] = tx_gapclk_select_regs[idx];
         if (paddr == OFS_STATUS) prdata[12:0] = {tx_chan_sys, 3'h0, rx_chan_sys};
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Flatten maps: bit j of register k is channel 8k+j
   always_comb begin
      for (int k = 0; k < NUM_BLK_REGS; k++) begin
         rx_blk_flat[k*8 +: 8] = rx_channel_block_regs[k];
         rx_gcs_flat[k*8 +: 8] = rx_gapclk_select_regs[k];
         tx_gcs_flat[k*8 +: 8] = tx_gapclk_select_regs[k];
         tx_blk_flat[k*8 +: 8] = (k >= T1_BLK_REGS
            && tx_io_control_reg[BIT_T1_BACKPLANE]) ? REG_RESET
            : tx_channel_block_regs[k];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Crossing into the link domains; maps are quasi-static, bits synced singly
   logic [67:0] rx_cfg_src, rx_cfg, tx_cfg_src, tx_cfg;
   assign rx_cfg_src = {rx_io_control_reg[BIT_CT_BUS_EN],
      rx_io_control_reg[BIT_SYNC_INV], rx_elastic_store_ctrl[BIT_GAPCLK_EN],
      rx_elastic_store_ctrl[BIT_FMT_56K], rx_blk_flat, rx_gcs_flat};
   assign tx_cfg_src = {rx_io_control_reg[BIT_CT_BUS_EN],
      tx_io_control_reg[BIT_SYNC_INV], tx_elastic_store_ctrl[BIT_GAPCLK_EN],
      tx_elastic_store_ctrl[BIT_FMT_56K], tx_blk_flat, tx_gcs_flat};
   logic rx_sync_pin, tx_sync_pin;
   sync_bit u_rx_rst (.clk(rx_bp_clk), .rst(1'b0), .d(reset), .q(rx_bp_rst));
   sync_bit u_tx_rst (.clk(tx_bp_clk), .rst(1'b0), .d(reset), .q(tx_bp_rst));
   for (genvar g = 0; g < 68; g++) begin : g_cfg
      sync_bit u_rx (.clk(rx_bp_clk), .rst(rx_bp_rst), .d(rx_cfg_src[g]), .q(rx_cfg[g]));
      sync_bit u_tx (.clk(tx_bp_clk), .rst(tx_bp_rst), .d(tx_cfg_src[g]), .q(tx_cfg[g]));
   end
   // Frame sync is an async pin: two flops before the sampling logic
   sync_bit u_rx_pin (.clk(rx_bp_clk), .rst(rx_bp_rst), .d(rx_frame_sync_pin),
      .q(rx_sync_pin));
   sync_bit u_tx_pin (.clk(tx_bp_clk), .rst(tx_bp_rst), .d(tx_sys_frame_sync_pin),
      .q(tx_sync_pin));
   ////////////////////////////////////////////////////////////////////////////
   chan_path u_rx (
      .bp_clk(rx_bp_clk), .bp_rst(rx_bp_rst),
      .ct_bus_en(rx_cfg[67]), .sync_inv(rx_cfg[66]),
      .gap_en(rx_cfg[65]), .fmt_56k(rx_cfg[64]),
      .blk_map(rx_cfg[63:32]), .gap_map(rx_cfg[31:0]),
      .sync_in(rx_sync_pin), .block_out(rx_channel_block_out),
      .chan_clk_out(rx_channel_clock_out), .chan(rx_chan)
   );
   chan_path u_tx (
      .bp_clk(tx_bp_clk), .bp_rst(tx_bp_rst),
      .ct_bus_en(tx_cfg[67]), .sync_inv(tx_cfg[66]),
      .gap_en(tx_cfg[65]), .fmt_56k(tx_cfg[64]),
      .blk_map(tx_cfg[63:32]), .gap_map(tx_cfg[31:0]),
      .sync_in(tx_sync_pin), .block_out(tx_channel_block_out),
      .chan_clk_out(tx_channel_clock_out), .chan(tx_chan)
   );
   // Channel numbers back to ref_clk; may tear mid-step, status only
   for (genvar c = 0; c < CHAN_BITS; c++) begin : g_stat
      sync_bit u_rs (.clk(ref_clk), .rst(reset), .d(rx_chan[c]), .q(rx_chan_sys[c]));
      sync_bit u_ts (.clk(ref_clk), .rst(reset), .d(tx_chan[c]), .q(tx_chan_sys[c]));
   end
   a_unmapped_err: assert property (@(posedge ref_clk) disable iff (reset)
      (access && !mapped) |-> pslverr && prdata == READ_ZERO)
      else $error("unmapped access not refused");
   a_write_lands: assert property (@(posedge ref_clk) disable iff (reset)
      (wr && paddr == OFS_TX_ES_CTRL) |=> tx_elastic_store_ctrl == $past(pwdata[7:0]))
      else $error("transmit elastic store control write lost");
   // A T1 backplane must never see the fourth transmit blocking register
   a_t1_fourth_mask: assert property (@(posedge ref_clk) disable iff (reset)
      tx_io_control_reg[BIT_T1_BACKPLANE] |-> tx_blk_flat[31:24] == REG_RESET)
      else $error("fourth transmit blocking register active on T1 backplane");
endmodule : backplane_channel_timing

// [src/bpt_pkg.sv]
// Constants and register map of the backplane channel timing block
package bpt_pkg;
   // APB register byte offsets
   localparam logic [7:0] OFS_RX_IO_CTRL = 8'h00;
   localparam logic [7:0] OFS_TX_IO_CTRL = 8'h04;
   localparam logic [7:0] OFS_RX_ES_CTRL = 8'h08;
   localparam logic [7:0] OFS_TX_ES_CTRL = 8'h0C;
   localparam logic [7:0] OFS_RX_BLK = 8'h10;
   localparam logic [7:0] OFS_TX_BLK = 8'h20;
   localparam logic [7:0] OFS_RX_GCS = 8'h30;
   localparam logic [7:0] OFS_TX_GCS = 8'h40;
   localparam logic [7:0] OFS_STATUS = 8'h50;
   localparam logic [7:0] GROUP_MASK = 8'hF0;
   // Field positions
   localparam int BIT_SYNC_INV = 0;
   localparam int BIT_CT_BUS_EN = 5;
   localparam int BIT_GAPCLK_EN = 6;
   localparam int BIT_FMT_56K = 7;
   localparam int BIT_T1_BACKPLANE = 0;
   // Widths and counts
   localparam int NUM_BLK_REGS = 4;
   localparam int T1_BLK_REGS = 3;
   localparam int CHAN_BITS = 5;
   localparam int NUM_CHANS = 32;
   localparam logic [2:0] DATA_CTRL_BIT = 3'h7;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage : bpt_pkg

// [src/sync_bit.sv]
// Two flip-flop level synchroniser
module sync_bit (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Level in and out
   input wire logic d,
   output logic q
);
   logic meta;
   // First stage only feeds the second
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= 1'b0;
         q <= 1'b0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : sync_bit

// [src/chan_path.sv]
// One backplane path: sync sampling, channel counter, blocking and gapped clock
module chan_path (
   // Link clock and reset
   input wire logic bp_clk,
   input wire logic bp_rst,
   // Configuration, already synchronised
   input wire logic ct_bus_en,
   input wire logic sync_inv,
   input wire logic gap_en,
   input wire logic fmt_56k,
   input wire logic [31:0] blk_map,
   input wire logic [31:0] gap_map,
   // Backplane pins
   input wire logic sync_in,
   output logic block_out,
   output logic chan_clk_out,
   // Current channel, for status
   output logic [4:0] chan
);
   import bpt_pkg::*;
   logic sync_pol, sync_rise, sync_fall, sync_q, frame_start;
   logic [2:0] bit_cnt;
   logic gap_gate;
   assign sync_pol = sync_in ^ sync_inv;
   // Normal mode samples on rising edge; CT-bus mode on falling edge
   always_ff @(posedge bp_clk) begin
      if (bp_rst) sync_rise <= 1'b0;
      else sync_rise <= sync_pol;
   end
   always_ff @(negedge bp_clk) begin
      if (bp_rst) sync_fall <= 1'b0;
      else sync_fall <= sync_pol;
   end
   always_ff @(posedge bp_clk) begin
      if (bp_rst) sync_q <= 1'b0;
      else sync_q <= ct_bus_en ? sync_fall : sync_rise;
   end
   assign frame_start = (ct_bus_en ? sync_fall : sync_rise) & ~sync_q;
   // Bit and channel counters, realigned on each frame sync
   always_ff @(posedge bp_clk) begin
      if (bp_rst || frame_start) begin
         bit_cnt <= 3'h0;
         chan <= 5'h00;
      end else begin
         bit_cnt <= bit_cnt + 3'h1;
         if (bit_cnt == DATA_CTRL_BIT) chan <= chan + 5'h01;
      end
   end
   // Block is a flop, held across the whole channel time
   always_ff @(posedge bp_clk) begin
      if (bp_rst) block_out <= 1'b0;
      else block_out <= blk_map[frame_start ? 5'h00 :
         (bit_cnt == DATA_CTRL_BIT ? chan + 5'h01 : chan)];
   end
   // Gate latched on falling edge so the clock never glitches
   always_ff @(negedge bp_clk) begin
      if (bp_rst) gap_gate <= 1'b0;
      else gap_gate <= gap_en && gap_map[chan]
         && !(fmt_56k && bit_cnt == DATA_CTRL_BIT);
   end
   assign chan_clk_out = bp_clk & gap_gate;
   a_gap_56k_omit: assert property (@(negedge bp_clk) disable iff (bp_rst)
      (fmt_56k && bit_cnt == DATA_CTRL_BIT) |=> !gap_gate)
      else $error("gapped clock present on data/control bit");
   a_gap_off: assert property (@(negedge bp_clk) disable iff (bp_rst)
      !gap_en |=> !gap_gate)
      else $error("gapped clock while disabled");
   a_chan_step: assert property (@(posedge bp_clk) disable iff (bp_rst)
      (bit_cnt == DATA_CTRL_BIT && !frame_start) |=> chan == $past(chan) + 5'h01)
      else $error("channel did not advance after eight bits");
endmodule : chan_path

// [dv/bp_partner.sv]
// Backplane far-side model: link clock, frame sync and output monitor
module bp_partner #(parameter real START = 0.0) (
   // Link clock and frame sync into the block
   output logic bp_clk,
   output logic sync,
   input wire logic inv,
   // Block outputs watched
   input wire logic block,
   input wire logic chclk,
   // Results of the last whole frame
   output int blk_cnt,
   output int clk_cnt,
   output int first_ofs,
   output int frames
);
   timeunit 1ns;
   timeprecision 1ps;
   int bit_ix = 0;
   int blk_acc = 0;
   int pulses = 0;
   int mark = 0;
   logic blk_q = 1'b0;
   ////////////////////////////////////////////////////////////////////////////
   // Free running link clock, as a TDM bus keeps it; stands in for the bus rate
   initial begin
      bp_clk = 1'b0;
      sync = 1'b0;
      frames = 0;
      first_ofs = 0;
      #(START);
      forever #6 bp_clk = ~bp_clk;
   end
   // Counted on the fall, clear of the rising edge that snapshots it
   always @(negedge chclk) pulses++;
   // 32 channels of 8 bits; sync high over the first four bits
   always @(posedge bp_clk) begin
      sync <= (bit_ix < 4) ^ inv;
      bit_ix <= (bit_ix + 1) % 256;
      blk_q <= block;
      blk_acc <= blk_acc + block;
      if (block && !blk_q) first_ofs <= bit_ix;
      if (bit_ix == 255) begin
         blk_cnt <= blk_acc + block;
         blk_acc <= 0;
         clk_cnt <= pulses - mark;
         mark <= pulses;
         frames <= frames + 1;
      end
   end
endmodule : bp_partner

// [dv/backplane_channel_timing_tb.sv]
// Self-checking bench of the backplane channel timing block
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
   $display("ERROR %0t got %0d want %0d", $time, a, b); end end
module backplane_channel_timing_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import bpt_pkg::*;
   logic ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, rx_clk, rx_sync, tx_clk, tx_sync;
   logic rx_blk_o, rx_ck_o, tx_blk_o, tx_ck_o, rx_inv = 1'b0, tx_inv = 1'b0;
   int err_total = 0, comparisons = 0;
   int rx_blk, rx_ck, rx_ofs, rx_frm, tx_blk, tx_ck, tx_ofs, tx_frm;
   ////////////////////////////////////////////////////////////////////////////
   backplane_channel_timing i_dut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_bp_clk(rx_clk),
      .rx_frame_sync_pin(rx_sync), .rx_channel_block_out(rx_blk_o),
      .rx_channel_clock_out(rx_ck_o), .tx_bp_clk(tx_clk),
      .tx_sys_frame_sync_pin(tx_sync), .tx_channel_block_out(tx_blk_o),
      .tx_channel_clock_out(tx_ck_o));
   bp_partner #(.START(0.0)) i_rx_far (.bp_clk(rx_clk), .sync(rx_sync), .inv(rx_inv),
      .block(rx_blk_o), .chclk(rx_ck_o), .blk_cnt(rx_blk), .clk_cnt(rx_ck),
      .first_ofs(rx_ofs), .frames(rx_frm));
   bp_partner #(.START(3.7)) i_tx_far (.bp_clk(tx_clk), .sync(tx_sync), .inv(tx_inv),
      .block(tx_blk_o), .chclk(tx_ck_o), .blk_cnt(tx_blk), .clk_cnt(tx_ck),
      .first_ofs(tx_ofs), .frames(tx_frm));
   always #12.5 ref_clk = ~ref_clk;
   // One APB transfer; held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk) penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   // Four receive and three transmit frames: config crossing plus one whole frame measured
   task automatic settle;
      int f;
      f = tx_frm;
      while (rx_frm < f + 4 || tx_frm < f + 3) @(posedge ref_clk);
   endtask : settle
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_block;
      logic [31:0] q;
      logic e;
      apb(1'b0, OFS_RX_IO_CTRL, 32'h0, q, e);
      `CHK(q, 32'h0)
      apb(1'b0, 8'h60, 32'h0, q, e);
      `CHK(e, 1'b1)
      wr(OFS_RX_BLK, 32'h05);
      wr(OFS_RX_BLK + 8'h0C, 32'h80);
      apb(1'b0, OFS_RX_BLK, 32'h0, q, e);
      `CHK(q, 32'h05)
      `CHK(e, 1'b0)
      settle;
      `CHK(rx_blk, 24)
      `CHK(tx_blk, 0)
      wr(OFS_RX_BLK, 32'h0);
      wr(OFS_RX_BLK + 8'h0C, 32'h0);
      wr(OFS_TX_BLK, 32'h01);
      wr(OFS_TX_BLK + 8'h0C, 32'hFF);
      settle;
      `CHK(tx_blk, 72)
      tx_inv <= 1'b1;
      wr(OFS_TX_IO_CTRL, 32'h01);
      settle;
      `CHK(tx_blk, 8)
      wr(OFS_TX_BLK + 8'h0C, 32'h0);
   endtask : t_block
   // 64k, 56k and off in turn on both paths
   task automatic t_gap;
      logic [7:0] es[3] = '{8'h40, 8'hC0, 8'h00};
      int tw[3] = '{16, 14, 0};
      int rw[3] = '{8, 7, 0};
      wr(OFS_TX_GCS + 8'h04, 32'h03);
      wr(OFS_RX_GCS + 8'h08, 32'h01);
      for (int i = 0; i < 3; i++) begin
         wr(OFS_TX_ES_CTRL, {24'h0, es[i]});
         wr(OFS_RX_ES_CTRL, {24'h0, es[i]});
         settle;
         `CHK(tx_ck, tw[i])
         `CHK(rx_ck, rw[i])
      end
   endtask : t_gap
   // Sync sampling: CT-bus mode with and without inversion
   task automatic t_sync;
      int o_rx, o_tx;
      wr(OFS_RX_BLK, 32'h02);
      wr(OFS_TX_BLK, 32'h02);
      settle;
      o_rx = rx_ofs;
      o_tx = tx_ofs;
      `CHK((o_rx >= 8) && (o_rx <= 14), 1'b1)
      rx_inv <= 1'b1;
      wr(OFS_RX_IO_CTRL, 32'h21);
      settle;
      `CHK((rx_ofs - o_rx) inside {[-1:1]}, 1'b1)
      `CHK((tx_ofs - o_tx) inside {[-1:1]}, 1'b1)
      wr(OFS_RX_IO_CTRL, 32'h20);
      settle;
      `CHK((rx_ofs - o_rx) inside {[3:5]}, 1'b1)
   endtask : t_sync
   task automatic close_out;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence; CT-bus use runs with both elastic store controls cleared to 0x00
   initial begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      t_block;
      t_gap;
      t_sync;
      close_out;
   end
   // Watchdog, about nine times the expected run
   initial begin
      repeat (40000) @(posedge ref_clk);
      err_total++;
      close_out;
   end
endmodule : backplane_channel_timing_tb
